// File: add_and_execute_datapath.sv
`timescale 1ns/1ps
// Function
// RQ1 - Add sums accumulator and file and updates carry, digit carry and zero.
// RQ2 - A file op writes to the accumulator on destination 0, the file on 1.
// RQ3 - AND literal ANDs accumulator with literal into it, updates only zero.
// RQ4 - AND with file ANDs accumulator and file, sets only zero, routes by d.
// RQ5 - Each op is one word and four phases: decode, read, process, write.
// RQ6 - Zero marks a zero result; add carries out of bit 7 and bit 3.
module add_and_execute_datapath
    import alu_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Instruction from decoder, taken in the decode phase
    input wire logic start,
    input wire logic [alu_pkg::WORD_W-1:0] instr,
    // File register memory
    output logic [alu_pkg::ADDR_W-1:0] file_addr,
    output logic file_read,
    input wire logic [alu_pkg::DATA_W-1:0] file_rdata,
    output logic file_write,
    output logic [alu_pkg::DATA_W-1:0] file_wdata,
    // Architectural state and status
    output logic [alu_pkg::DATA_W-1:0] accum,
    output logic carry_flag,
    output logic digit_carry_flag,
    output logic zero_flag,
    output logic busy,
    output logic done
);
    import alu_pkg::*;

    // =========================================================
    // Elaboration checks
    // =========================================================
    // Field slices and the internal bytes are fixed to this layout, so a
    // package edit that moves a field must stop the build, not misdecode.
    if (DATA_W != 8 || WORD_W != OPC_MSB + 1 || OPC_LSB != DEST_BIT + 1
        || DEST_BIT != ADDR_W || ADDR_MSB != ADDR_W - 1
        || LIT_MSB != DATA_W - 1)
    begin : g_layout_bad
        $error("instruction layout does not fit the datapath");
    end
    // The sequencer has one state per phase and cannot stretch.
    if (PHASES != 4)
    begin : g_phases_bad
        $error("the datapath serves exactly four phases");
    end

    // =========================================================
    // Phase sequencer
    // =========================================================
    phase_e phase_reg;
    logic [5:0] opc_reg;
    logic dest_reg;
    logic [7:0] lit_reg;
    logic [7:0] operand;
    logic [7:0] result_reg;
    logic carry_reg, digit_carry_reg, zero_reg, use_carry_reg, valid_reg;
    logic [7:0] result;
    logic carry, digit_carry, zero, use_carry, valid;
    logic is_lit;

    assign is_lit = (opc_reg == OPC_AND_LITERAL_INTO_ACCUM);

    // File memory answers one cycle after file_read, so its byte stands
    // only in the process phase; it feeds the adder straight from the
    // port there, and the result register of that phase keeps the outcome.
    assign operand = is_lit ? lit_reg : file_rdata; // [RQ3]

    // Phases only advance once started so an idle core holds still.
    // A start outside the decode phase is ignored, since the word would
    // collide with the one already in flight.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            phase_reg <= PH_DECODE;
        else
        begin
            unique case (phase_reg)
                PH_DECODE: if (start) phase_reg <= PH_READ; // [RQ5]
                PH_READ: phase_reg <= PH_PROCESS; // [RQ5]
                PH_PROCESS: phase_reg <= PH_WRITE; // [RQ5]
                PH_WRITE: phase_reg <= PH_DECODE; // [RQ5]
            endcase
        end
    end

    // =========================================================
    // Decode and operand read
    // =========================================================
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            opc_reg <= 6'h00;
            dest_reg <= DEST_ACCUM;
            lit_reg <= 8'h00;
            file_addr <= 7'h00;
            file_read <= 1'b0;
        end
        else
        begin
            file_read <= 1'b0;
            if (phase_reg == PH_DECODE && start)
            begin
                opc_reg <= instr[OPC_MSB:OPC_LSB];
                dest_reg <= instr[DEST_BIT];
                lit_reg <= instr[LIT_MSB:0];
                file_addr <= instr[ADDR_MSB:0];
                // The literal form never touches file memory.
                file_read <= (instr[OPC_MSB:OPC_LSB]
                    != OPC_AND_LITERAL_INTO_ACCUM);
            end
        end
    end

    // =========================================================
    // Process
    // =========================================================
    alu_core u_core (
        .opcode(opc_reg),
        .accum(accum),
        .operand(operand),
        .result(result),
        .carry(carry),
        .digit_carry(digit_carry),
        .zero(zero),
        .use_carry(use_carry),
        .valid(valid)
    );

    // Results are registered at the end of the process phase, so the
    // write phase drives every output from flip-flops and the adder
    // never reaches a pin.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            result_reg <= 8'h00;
            carry_reg <= 1'b0;
            digit_carry_reg <= 1'b0;
            zero_reg <= 1'b0;
            use_carry_reg <= 1'b0;
            valid_reg <= 1'b0;
        end
        else if (phase_reg == PH_PROCESS)
        begin
            result_reg <= result;
            carry_reg <= carry;
            digit_carry_reg <= digit_carry;
            zero_reg <= zero;
            use_carry_reg <= use_carry;
            valid_reg <= valid;
        end
    end

    // =========================================================
    // Write destination and flags
    // =========================================================
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            accum <= ACCUM_RESET;
            file_write <= 1'b0;
            file_wdata <= 8'h00;
            carry_flag <= 1'b0;
            digit_carry_flag <= 1'b0;
            zero_flag <= 1'b0;
        end
        else
        begin
            file_write <= 1'b0;
            // Unknown opcodes leave all state untouched.
            // file_wdata keeps the last written byte; only the file_write
            // pulse tells the memory that a write is due.
            if (phase_reg == PH_WRITE && valid_reg)
            begin
                if (is_lit || dest_reg == DEST_ACCUM)
                    accum <= result_reg; // [RQ2] [RQ3]
                else
                begin
                    file_write <= 1'b1; // [RQ2]
                    file_wdata <= result_reg; // [RQ2]
                end
                zero_flag <= zero_reg; // [RQ6]
                // Carry and digit carry keep their value across the AND
                // forms, which affect only zero.
                if (use_carry_reg)
                begin
                    carry_flag <= carry_reg; // [RQ1]
                    digit_carry_flag <= digit_carry_reg; // [RQ1]
                end
            end
        end
    end

    // =========================================================
    // Status outputs
    // =========================================================
    // done marks the cycle in which destination and flags are settled.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            done <= 1'b0;
        else
            done <= (phase_reg == PH_WRITE); // [RQ5]
    end

    // busy falls in the cycle in which done rises, the earliest cycle in which the
    // decoder may offer the next word; a start offered while busy is
    // high is dropped rather than queued.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            busy <= 1'b0;
        else if (phase_reg == PH_DECODE)
            busy <= start; // [RQ5]
        else
            busy <= (phase_reg != PH_WRITE); // [RQ5]
    end
endmodule

// File: alu_asserts.sv
`timescale 1ns/1ps
module alu_asserts
    import alu_pkg::*;
(
    // Watched ports
    input wire logic clock,
    input wire logic reset_n,
    input wire logic start,
    input wire logic [alu_pkg::WORD_W-1:0] instr,
    input wire logic [alu_pkg::ADDR_W-1:0] file_addr,
    input wire logic file_read,
    input wire logic [alu_pkg::DATA_W-1:0] file_rdata,
    input wire logic file_write,
    input wire logic [alu_pkg::DATA_W-1:0] file_wdata,
    input wire logic [alu_pkg::DATA_W-1:0] accum,
    input wire logic carry_flag,
    input wire logic digit_carry_flag,
    input wire logic zero_flag,
    input wire logic busy,
    input wire logic done
);
    import alu_pkg::*;
    logic [1:0] ph_reg;
    logic [5:0] op;
    assign op = instr[OPC_MSB:OPC_LSB];
    // Phase counter; a start is taken only when it reads zero.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            ph_reg <= 2'h0;
        else if (ph_reg != 2'h0 || start)
            ph_reg <= ph_reg + 2'h1;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence take_s(o);
        ph_reg == 2'h0 && start && op == o;
    endsequence
    AST_READ: assert property (
        take_s(OPC_AND_ACCUM_WITH_FILE) |=> file_read ##1 !file_read)
        else $error("read pulse wrong");
    AST_LIT_NO_READ: assert property (
        take_s(OPC_AND_LITERAL_INTO_ACCUM) |=> !file_read [*4])
        else $error("literal op read file");
    AST_DONE: assert property (
        (ph_reg == 2'h0 && start) |-> ##3 !done ##1 done)
        else $error("done not after four phases");
    AST_BUSY: assert property (
        (ph_reg == 2'h0 && start) |=> busy [*3] ##1 !busy)
        else $error("busy not high for three cycles");
    AST_ADDR: assert property (
        (ph_reg == 2'h0 && start) |=> file_addr == $past(instr[ADDR_MSB:0]))
        else $error("file address not latched");
    AST_ADD_SUM: assert property (
        take_s(OPC_ADD_ACCUM_TO_FILE) ##0 !instr[DEST_BIT] |-> ##4 !file_write
        && accum == 8'($past(accum, 4) + $past(file_rdata, 2)))
        else $error("add result wrong");
    AST_ADD_CARRY: assert property (
        take_s(OPC_ADD_ACCUM_TO_FILE) |-> ##4 carry_flag ==
        ({1'b0, $past(accum, 4)} + {1'b0, $past(file_rdata, 2)} > 9'h0FF)
        && digit_carry_flag == (($past(accum, 4) & 8'h0F)
        + ($past(file_rdata, 2) & 8'h0F) > 8'h0F))
        else $error("add carries wrong");
    AST_WRITE_BACK: assert property (
        take_s(OPC_AND_ACCUM_WITH_FILE) ##0 instr[DEST_BIT] |-> ##4 file_write
        && file_wdata == ($past(accum, 4) & $past(file_rdata, 2))
        && accum == $past(accum, 4))
        else $error("write back wrong");
    AST_ZERO: assert property (
        done && file_write |-> zero_flag == (file_wdata == 8'h00))
        else $error("zero flag wrong");
    AST_LIT: assert property (
        take_s(OPC_AND_LITERAL_INTO_ACCUM) |-> ##4 carry_flag ==
        $past(carry_flag, 4) && accum == 8'($past(accum, 4) & $past(instr, 4)))
        else $error("literal and wrong");
endmodule
bind add_and_execute_datapath alu_asserts asserts_u (.clock, .reset_n,
    .start, .instr, .file_addr, .file_read, .file_rdata, .file_write,
    .file_wdata, .accum, .carry_flag, .digit_carry_flag, .zero_flag,
    .busy, .done);

// File: alu_core.sv
`timescale 1ns/1ps
module alu_core
    import alu_pkg::*;
(
    // Operands
    input wire logic [5:0] opcode,
    input wire logic [7:0] accum,
    input wire logic [7:0] operand,
    // Result
    output logic [7:0] result,
    output logic carry,
    output logic digit_carry,
    output logic zero,
    output logic use_carry,
    output logic valid
);
    logic [8:0] sum;
    logic [4:0] low_sum;

    assign sum = {1'b0, accum} + {1'b0, operand};
    assign low_sum = {1'b0, accum[3:0]} + {1'b0, operand[3:0]};

    always_comb
    begin
        result = 8'h00;
        use_carry = 1'b0;
        valid = 1'b1;
        unique case (opcode)
            OPC_ADD_ACCUM_TO_FILE:
            begin
                result = sum[7:0]; // [RQ1]
                use_carry = 1'b1;
            end
            OPC_AND_ACCUM_WITH_FILE: result = accum & operand; // [RQ4]
            OPC_AND_LITERAL_INTO_ACCUM: result = accum & operand; // [RQ3]
            default: valid = 1'b0;
        endcase
        carry = sum[8]; // [RQ6]
        digit_carry = low_sum[4]; // [RQ6]
        zero = (result == 8'h00); // [RQ6]
    end
endmodule

// File: alu_pkg.sv
package alu_pkg;
    // =========================================================
    // Instruction word layout
    // =========================================================
    localparam int WORD_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int OPC_MSB = 13;
    localparam int OPC_LSB = 8;
    localparam int DEST_BIT = 7;
    localparam int ADDR_MSB = 6;
    localparam int LIT_MSB = 7;
    localparam logic [5:0] OPC_ADD_ACCUM_TO_FILE = 6'h07;
    localparam logic [5:0] OPC_AND_ACCUM_WITH_FILE = 6'h05;
    localparam logic [5:0] OPC_AND_LITERAL_INTO_ACCUM = 6'h39;
    localparam logic DEST_ACCUM = 1'b0;
    localparam logic DEST_FILE = 1'b1;
    // =========================================================
    // Reset values and phases
    // =========================================================
    localparam logic [7:0] ACCUM_RESET = 8'h00;
    localparam int PHASES = 4;
    typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE}
        phase_e;
endpackage

// File: file_mem_model.sv
`timescale 1ns/1ps
module file_mem_model
(
    // File port
    input wire logic clock,
    input wire logic [6:0] file_addr,
    input wire logic file_read,
    input wire logic file_write,
    input wire logic [7:0] file_wdata,
    output logic [7:0] file_rdata
);
    logic [7:0] mem [128];
    initial
    begin
        for (int i = 0; i < 128; i++)
            mem[i] = 8'(i * 37 + 5);
        file_rdata = 8'h00;
    end
    // Data stand one cycle only; the line flips after so stale use shows.
    always @(posedge clock)
    begin
        file_rdata <= file_read ? mem[file_addr] : ~file_rdata;
        if (file_write)
            mem[file_addr] <= file_wdata;
    end
endmodule

// File: tb.sv
`timescale 1ns/1ps
module tb;
    import alu_pkg::*;
    logic clock, reset_n, start, file_read, file_write, busy, done;
    logic [13:0] instr;
    logic [6:0] file_addr;
    logic [7:0] file_rdata, file_wdata, accum, w, wd;
    logic [7:0] mem [128];
    logic carry_flag, digit_carry_flag, zero_flag, c, hc, z, wr;
    logic [5:0] op;
    logic [19:0] q [$];
    logic [31:0] rs = 32'h65AAC64A;
    int n_errors = 0;
    int samples_checked = 0;
    add_and_execute_datapath dut_u (.clock, .reset_n, .start, .instr,
        .file_addr, .file_read, .file_rdata, .file_write, .file_wdata,
        .accum, .carry_flag, .digit_carry_flag, .zero_flag, .busy, .done);
    file_mem_model mem_u (.clock, .file_addr, .file_read, .file_write,
        .file_wdata, .file_rdata);
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // =========================================================
    // Issue one word; hold keeps start high while busy.
    // =========================================================
    task automatic issue(input logic [13:0] i, input logic hold);
        logic [7:0] f, r;
        logic [8:0] s;
        f = mem[i[6:0]];
        r = i[7:0] & w;
        wr = 1'b0;
        if (i[13:8] == OPC_ADD_ACCUM_TO_FILE)
        begin
            s = {1'b0, w} + {1'b0, f};
            r = s[7:0];
            c = s[8];
            hc = ({1'b0, w[3:0]} + {1'b0, f[3:0]}) > 5'h0F;
        end
        else if (i[13:8] == OPC_AND_ACCUM_WITH_FILE)
            r = w & f;
        if (i[13:8] inside {OPC_ADD_ACCUM_TO_FILE, OPC_AND_ACCUM_WITH_FILE,
            OPC_AND_LITERAL_INTO_ACCUM})
        begin
            z = r == 8'h00;
            wr = i[7] && i[13:8] != OPC_AND_LITERAL_INTO_ACCUM;
            if (wr)
                mem[i[6:0]] = r;
            if (wr)
                wd = r;
            else
                w = r;
        end
        q.push_back({w, c, hc, z, wr, wd});
        start <= 1'b1;
        instr <= i;
        @(posedge clock);
        repeat (3)
        begin
            rs = xs(rs);
            start <= hold;
            instr <= rs[13:0];
            @(posedge clock);
        end
    endtask
    always @(negedge clock)
        if (done === 1'b1)
        begin
            if (q.size() == 0)
                n_errors++;
            else
                check({accum, carry_flag, digit_carry_flag, zero_flag,
                    file_write, file_wdata},
                    q.pop_front());
        end
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial
    begin
        reset_n = 1'b0;
        start = 1'b0;
        instr = 14'h0000;
        {w, wd, c, hc, z} = 19'h00000;
        for (int i = 0; i < 128; i++)
            mem[i] = 8'(i * 37 + 5);
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        for (int n = 0; n < 400; n++)
        begin
            rs = xs(rs);
            case (rs[18:16])
                3'h4: op = OPC_AND_ACCUM_WITH_FILE;
                3'h5: op = OPC_AND_LITERAL_INTO_ACCUM;
                3'h6: op = 6'h3F;
                default: op = OPC_ADD_ACCUM_TO_FILE;
            endcase
            issue({op, rs[7:0]}, rs[20]);
        end
        start <= 1'b0;
        for (int n = 0; n < 20 && q.size() > 0; n++)
            @(posedge clock);
        if (q.size() > 0)
            n_errors++;
        $display("random instruction test done");
        results();
    end
endmodule
